// ---- rtl/ash_pkg.sv ----
// constants, types and field decoders for the security header codec
// assumes octets travel least significant octet first
package ash_pkg;

    // ****************************************
    // field layout of the control octet
    // ****************************************
    localparam int OCTET_W = 8;
    localparam int LVL_LSB = 0;
    localparam int LVL_W = 3;
    localparam int MODE_LSB = 3;
    localparam int MODE_W = 2;
    localparam int ENC_BIT = 2;
    localparam logic [2:0] RSVD_ZERO = 3'h0;

    // ****************************************
    // field sizes and octet positions
    // ****************************************
    localparam int FC_W = 32;
    localparam int SRC_W = 64;
    localparam logic [3:0] POS_CTRL = 4'h0;
    localparam logic [3:0] POS_FC_LAST = 4'h4;
    localparam logic [3:0] POS_KEY = 4'h5;
    localparam logic [3:0] SRC_LEN0 = 4'h0;
    localparam logic [3:0] SRC_LEN4 = 4'h4;
    localparam logic [3:0] SRC_LEN8 = 4'h8;
    localparam logic [3:0] POS_ONE = 4'h1;

    // ****************************************
    // codes
    // ****************************************
    localparam logic [1:0] KMODE_IMPLICIT = 2'h0;
    localparam logic [1:0] KMODE_DEFAULT = 2'h1;
    localparam logic [1:0] KMODE_SRC4 = 2'h2;
    localparam logic [1:0] KMODE_SRC8 = 2'h3;
    localparam logic [2:0] LVL_NONE = 3'h0;
    localparam logic [4:0] TAG_NONE = 5'h00;
    localparam logic [4:0] TAG_4 = 5'h04;
    localparam logic [4:0] TAG_8 = 5'h08;
    localparam logic [4:0] TAG_16 = 5'h10;
    localparam logic [7:0] KEY_IDX_BAD = 8'h00;
    localparam logic [31:0] FC_RESET = 32'h00000000;
    localparam logic [31:0] FC_ONE = 32'h00000001;

    typedef logic [2:0] ash_lvl_t;
    typedef logic [1:0] ash_kmode_t;

    // key source octets per key identifier mode
    function automatic logic [3:0] ash_src_len(input ash_kmode_t mode);
        case (mode)
            KMODE_SRC4: ash_src_len = SRC_LEN4;
            KMODE_SRC8: ash_src_len = SRC_LEN8;
            default: ash_src_len = SRC_LEN0;
        endcase
    endfunction

    // position of the final header octet
    function automatic logic [3:0] ash_last_pos(input ash_kmode_t mode);
        if (mode == KMODE_IMPLICIT) begin
            ash_last_pos = POS_FC_LAST;
        end else begin
            ash_last_pos = POS_FC_LAST + ash_src_len(mode) + POS_ONE;
        end
    endfunction

    function automatic logic [4:0] ash_tag_len(input ash_lvl_t lvl);
        case (lvl[1:0])
            2'h1: ash_tag_len = TAG_4;
            2'h2: ash_tag_len = TAG_8;
            2'h3: ash_tag_len = TAG_16;
            default: ash_tag_len = TAG_NONE;
        endcase
    endfunction

    // first level offers at least the protection of the second
    function automatic logic ash_level_ge(input ash_lvl_t a,
                                          input ash_lvl_t b);
        ash_level_ge = (a[ENC_BIT] >= b[ENC_BIT]) && (a[1:0] >= b[1:0]);
    endfunction

endpackage

// ---- rtl/ash_link_if.sv ----
// octet link between the header codec and the mac datapath
// assumes both ends share one clock
`timescale 1ns/1ps
interface ash_link_if;
    // codec to mac: built header octets
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
    logic tx_ready;
    // mac to codec: received header octets
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_ready;

    modport codec (
        output tx_valid, tx_data, tx_last, rx_ready,
        input tx_ready, rx_valid, rx_data
    );
    modport mac (
        input tx_valid, tx_data, tx_last, rx_ready,
        output tx_ready, rx_valid, rx_data
    );
endinterface

// ---- rtl/ash_fifo.sv ----
// synchronous fifo with valid/ready on both sides
// assumes one clock, depth a power of two
`timescale 1ns/1ps
module ash_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    assign o_in_ready = (count_ff != (AW+1)'(DEPTH));
    assign o_out_valid = (count_ff != '0);
    assign o_out_data = mem[rd_ptr_ff];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + AW'(1);
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + AW'(1);
            end
            if (push && !pop) begin
                count_ff <= count_ff + (AW+1)'(1);
            end else if (pop && !push) begin
                count_ff <= count_ff - (AW+1)'(1);
            end
        end
    end
endmodule

// ---- rtl/ash_codec.sv ----
// security header codec: builds and parses the auxiliary header
// assumes the mac end sits on the same clock across ash_link_if
`timescale 1ns/1ps

module ash_codec (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // transmit request
    input wire logic i_tx_req,
    input wire logic i_tx_sec_en,
    input wire ash_pkg::ash_lvl_t i_tx_level,
    input wire ash_pkg::ash_kmode_t i_tx_kmode,
    input wire logic [63:0] i_tx_key_src,
    input wire logic [7:0] i_tx_key_idx,
    output logic o_tx_busy,
    output logic o_tx_done,
    output logic [31:0] o_tally,
    // receive results
    input wire ash_pkg::ash_lvl_t i_min_level,
    output logic o_rx_valid,
    output ash_pkg::ash_lvl_t o_rx_level,
    output ash_pkg::ash_kmode_t o_rx_kmode,
    output logic o_rx_encrypt,
    output logic [4:0] o_rx_tag_len,
    output logic [31:0] o_rx_fc,
    output logic [63:0] o_rx_key_src,
    output logic [7:0] o_rx_key_idx,
    output logic o_rx_level_ok,
    output logic o_rx_replay,
    output logic o_rx_bad_idx,
    // link to mac end
    ash_link_if.codec link
);

    typedef ash_pkg::ash_lvl_t ash_lvl_t;
    typedef ash_pkg::ash_kmode_t ash_kmode_t;

    // ****************************************
    // transmit side
    // ****************************************
    typedef enum logic [1:0] {
        ASH_TX_IDLE = 2'b00,
        ASH_TX_SEND = 2'b01
    } ash_tx_st_t;

    ash_tx_st_t tx_st_ff;
    logic [3:0] tx_pos_ff;
    ash_lvl_t tx_lvl_ff;
    ash_kmode_t tx_mode_ff;
    logic [63:0] tx_src_ff;
    logic [7:0] tx_idx_ff;
    logic [31:0] tally_ff;
    logic tx_valid_ff;
    logic [7:0] tx_data_ff;
    logic tx_last_ff;
    logic tx_done_ff;
    logic tx_fire;
    logic [3:0] nxt_tx_pos;

    function automatic logic [7:0] tx_octet(input logic [3:0] pos,
                                            input ash_lvl_t lvl,
                                            input ash_kmode_t mode,
                                            input logic [31:0] fc,
                                            input logic [63:0] src,
                                            input logic [7:0] idx);
        logic [3:0] off;
        off = pos - ash_pkg::POS_KEY;
        if (pos == ash_pkg::POS_CTRL) begin
            tx_octet = {ash_pkg::RSVD_ZERO, mode, lvl};
        end else if (pos < ash_pkg::POS_KEY) begin
            tx_octet = fc[8*(int'(pos)-1) +: 8];
        end else if (off < ash_pkg::ash_src_len(mode)) begin
            tx_octet = src[8*int'(off) +: 8];
        end else begin
            tx_octet = idx;
        end
    endfunction

    assign tx_fire = tx_valid_ff && link.tx_ready;
    assign nxt_tx_pos = tx_pos_ff + ash_pkg::POS_ONE;
    assign link.tx_valid = tx_valid_ff;
    assign link.tx_data = tx_data_ff;
    assign link.tx_last = tx_last_ff;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tx_st_ff <= ASH_TX_IDLE;
            tx_pos_ff <= ash_pkg::POS_CTRL;
            tx_lvl_ff <= ash_pkg::LVL_NONE;
            tx_mode_ff <= ash_pkg::KMODE_IMPLICIT;
            tx_src_ff <= '0;
            tx_idx_ff <= ash_pkg::KEY_IDX_BAD;
            tx_valid_ff <= 1'b0;
            tx_data_ff <= 8'h00;
            tx_last_ff <= 1'b0;
            tx_done_ff <= 1'b0;
        end else begin
            tx_done_ff <= 1'b0;
            case (tx_st_ff)
                ASH_TX_IDLE: begin
                    if (i_tx_req && !i_tx_sec_en) begin
                        tx_done_ff <= 1'b1;
                    end else if (i_tx_req) begin
                        tx_st_ff <= ASH_TX_SEND;
                        tx_lvl_ff <= i_tx_level;
                        tx_mode_ff <= i_tx_kmode;
                        tx_src_ff <= i_tx_key_src;
                        tx_idx_ff <= i_tx_key_idx;
                        tx_pos_ff <= ash_pkg::POS_CTRL;
                        tx_valid_ff <= 1'b1;
                        tx_last_ff <= 1'b0;
                        tx_data_ff <= tx_octet(ash_pkg::POS_CTRL,
                            i_tx_level, i_tx_kmode, tally_ff,
                            i_tx_key_src, i_tx_key_idx);
                    end
                end
                ASH_TX_SEND: begin
                    if (tx_fire && tx_last_ff) begin
                        tx_st_ff <= ASH_TX_IDLE;
                        tx_valid_ff <= 1'b0;
                        tx_last_ff <= 1'b0;
                        tx_done_ff <= 1'b1;
                    end else if (tx_fire) begin
                        tx_pos_ff <= nxt_tx_pos;
                        tx_data_ff <= tx_octet(nxt_tx_pos, tx_lvl_ff,
                            tx_mode_ff, tally_ff, tx_src_ff, tx_idx_ff);
                        tx_last_ff <= (nxt_tx_pos ==
                            ash_pkg::ash_last_pos(tx_mode_ff));
                    end
                end
                default: begin
                    tx_st_ff <= ASH_TX_IDLE;
                    tx_valid_ff <= 1'b0;
                end
            endcase
        end
    end

    // outgoing tally advances once per protected header sent
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tally_ff <= ash_pkg::FC_RESET;
        end else if (tx_fire && tx_last_ff &&
                     tx_lvl_ff != ash_pkg::LVL_NONE) begin
            tally_ff <= tally_ff + ash_pkg::FC_ONE;
        end
    end

    assign o_tx_busy = (tx_st_ff != ASH_TX_IDLE);
    assign o_tx_done = tx_done_ff;
    assign o_tally = tally_ff;

    // ****************************************
    // receive side
    // ****************************************
    typedef enum logic [1:0] {
        ASH_RX_CTRL = 2'b00,
        ASH_RX_FC = 2'b01,
        ASH_RX_KEY = 2'b11
    } ash_rx_st_t;

    ash_rx_st_t rx_st_ff;
    logic [3:0] rx_pos_ff;
    ash_lvl_t rx_lvl_ff;
    ash_kmode_t rx_mode_ff;
    logic [31:0] rx_fc_ff;
    logic [63:0] rx_src_ff;
    logic [7:0] rx_idx_ff;
    logic rx_done_ff;
    logic rx_fire;
    logic [3:0] rx_off;
    logic [31:0] last_fc_ff;
    logic have_fc_ff;
    logic replay;

    assign link.rx_ready = 1'b1;
    assign rx_fire = link.rx_valid;
    assign rx_off = rx_pos_ff - ash_pkg::POS_KEY;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_st_ff <= ASH_RX_CTRL;
            rx_pos_ff <= ash_pkg::POS_CTRL;
            rx_lvl_ff <= ash_pkg::LVL_NONE;
            rx_mode_ff <= ash_pkg::KMODE_IMPLICIT;
            rx_fc_ff <= ash_pkg::FC_RESET;
            rx_src_ff <= '0;
            rx_idx_ff <= ash_pkg::KEY_IDX_BAD;
            rx_done_ff <= 1'b0;
        end else begin
            rx_done_ff <= 1'b0;
            if (rx_fire) begin
                rx_pos_ff <= rx_pos_ff + ash_pkg::POS_ONE;
                case (rx_st_ff)
                    ASH_RX_CTRL: begin
                        // reserved bits dropped here
                        rx_lvl_ff <= link.rx_data[ash_pkg::LVL_LSB +:
                            ash_pkg::LVL_W];
                        rx_mode_ff <= link.rx_data[ash_pkg::MODE_LSB +:
                            ash_pkg::MODE_W];
                        rx_src_ff <= '0;
                        rx_idx_ff <= ash_pkg::KEY_IDX_BAD;
                        rx_st_ff <= ASH_RX_FC;
                    end
                    ASH_RX_FC: begin
                        rx_fc_ff[8*(int'(rx_pos_ff)-1) +: 8] <=
                            link.rx_data;
                        if (rx_pos_ff == ash_pkg::POS_FC_LAST) begin
                            if (rx_mode_ff == ash_pkg::KMODE_IMPLICIT) begin
                                rx_st_ff <= ASH_RX_CTRL;
                                rx_pos_ff <= ash_pkg::POS_CTRL;
                                rx_done_ff <= 1'b1;
                            end else begin
                                rx_st_ff <= ASH_RX_KEY;
                            end
                        end
                    end
                    ASH_RX_KEY: begin
                        if (rx_off < ash_pkg::ash_src_len(rx_mode_ff)) begin
                            rx_src_ff[8*int'(rx_off) +: 8] <= link.rx_data;
                        end else begin
                            rx_idx_ff <= link.rx_data;
                            rx_st_ff <= ASH_RX_CTRL;
                            rx_pos_ff <= ash_pkg::POS_CTRL;
                            rx_done_ff <= 1'b1;
                        end
                    end
                    default: begin
                        rx_st_ff <= ASH_RX_CTRL;
                        rx_pos_ff <= ash_pkg::POS_CTRL;
                    end
                endcase
            end
        end
    end

    // counter must move strictly forward for protected frames
    assign replay = (rx_lvl_ff != ash_pkg::LVL_NONE) && have_fc_ff &&
                    (rx_fc_ff <= last_fc_ff);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            last_fc_ff <= ash_pkg::FC_RESET;
            have_fc_ff <= 1'b0;
        end else if (rx_done_ff && !replay &&
                     rx_lvl_ff != ash_pkg::LVL_NONE) begin
            last_fc_ff <= rx_fc_ff;
            have_fc_ff <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rx_valid <= 1'b0;
            o_rx_level <= ash_pkg::LVL_NONE;
            o_rx_kmode <= ash_pkg::KMODE_IMPLICIT;
            o_rx_encrypt <= 1'b0;
            o_rx_tag_len <= ash_pkg::TAG_NONE;
            o_rx_fc <= ash_pkg::FC_RESET;
            o_rx_key_src <= '0;
            o_rx_key_idx <= ash_pkg::KEY_IDX_BAD;
            o_rx_level_ok <= 1'b0;
            o_rx_replay <= 1'b0;
            o_rx_bad_idx <= 1'b0;
        end else begin
            o_rx_valid <= rx_done_ff;
            if (rx_done_ff) begin
                o_rx_level <= rx_lvl_ff;
                o_rx_kmode <= rx_mode_ff;
                o_rx_encrypt <= rx_lvl_ff[ash_pkg::ENC_BIT];
                o_rx_tag_len <= ash_pkg::ash_tag_len(rx_lvl_ff);
                o_rx_fc <= rx_fc_ff;
                o_rx_key_src <= rx_src_ff;
                o_rx_key_idx <= rx_idx_ff;
                o_rx_level_ok <= ash_pkg::ash_level_ge(rx_lvl_ff,
                                                       i_min_level);
                o_rx_replay <= replay;
                o_rx_bad_idx <= (rx_mode_ff != ash_pkg::KMODE_IMPLICIT) &&
                    (rx_idx_ff == ash_pkg::KEY_IDX_BAD);
            end
        end
    end
endmodule

// ---- rtl/ash_mac.sv ----
// mac datapath end: feeds received header octets, drains built ones
// assumes the codec end sits on the same clock across ash_link_if
`timescale 1ns/1ps
module ash_mac #(
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // received frame header octets
    input wire logic i_sec_en,
    input wire logic i_hdr_valid,
    input wire logic [7:0] i_hdr_octet,
    output logic o_hdr_ready,
    // built header octets toward the frame
    output logic o_tx_valid,
    output logic [7:0] o_tx_octet,
    output logic o_tx_last,
    input wire logic i_tx_ready,
    // link to codec end
    ash_link_if.mac link
);

    // ****************************************
    // receive path toward the codec
    // ****************************************
    logic rx_valid_ff;
    logic [7:0] rx_data_ff;
    logic hdr_ready_ff;
    logic take;
    logic nxt_rx_valid;

    // octets of unsecured frames are swallowed, never forwarded
    assign take = i_hdr_valid && hdr_ready_ff;
    assign nxt_rx_valid = (rx_valid_ff && !link.rx_ready) ||
                          (take && i_sec_en);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_valid_ff <= 1'b0;
            rx_data_ff <= 8'h00;
            hdr_ready_ff <= 1'b0;
        end else begin
            rx_valid_ff <= nxt_rx_valid;
            if (take && i_sec_en) begin
                rx_data_ff <= i_hdr_octet;
            end
            hdr_ready_ff <= !nxt_rx_valid;
        end
    end

    assign link.rx_valid = rx_valid_ff;
    assign link.rx_data = rx_data_ff;
    assign o_hdr_ready = hdr_ready_ff;

    // ****************************************
    // transmit path through the fifo
    // ****************************************
    logic fifo_valid;
    logic [8:0] fifo_data;
    logic fifo_pop;
    logic out_valid_ff;
    logic [7:0] out_data_ff;
    logic out_last_ff;

    assign fifo_pop = !out_valid_ff || i_tx_ready;

    ash_fifo #(
        .WIDTH(9),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_in_valid(link.tx_valid),
        .i_in_data({link.tx_last, link.tx_data}),
        .o_in_ready(link.tx_ready),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_data),
        .i_out_ready(fifo_pop)
    );

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            out_valid_ff <= 1'b0;
            out_data_ff <= 8'h00;
            out_last_ff <= 1'b0;
        end else if (fifo_pop) begin
            out_valid_ff <= fifo_valid;
            out_data_ff <= fifo_data[7:0];
            out_last_ff <= fifo_data[8];
        end
    end

    assign o_tx_valid = out_valid_ff;
    assign o_tx_octet = out_data_ff;
    assign o_tx_last = out_last_ff;
endmodule

// ---- sim/ash_link_properties.sv ----
// checker on the octet link between codec and mac ends
// assumes one clock; instantiated beside the link interface
`timescale 1ns/1ps
module ash_link_properties (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // link signals
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_ready
);
    logic [3:0] cnt_ff;
    logic [1:0] kmode_ff;
    logic [1:0] mode;
    logic [3:0] last_at;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // octet index of the final header octet for the current key mode
    assign mode = (cnt_ff == 4'h0) ? tx_data[4:3] : kmode_ff;
    assign last_at = (mode == 2'h0) ? 4'h4 : (mode == 2'h1) ? 4'h5 :
        (mode == 2'h2) ? 4'h9 : 4'hD;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_ff <= 4'h0;
        end else if (tx_valid && tx_ready) begin
            cnt_ff <= tx_last ? 4'h0 : cnt_ff + 4'h1;
        end
    end
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            kmode_ff <= 2'h0;
        end else if (tx_valid && tx_ready && cnt_ff == 4'h0) begin
            kmode_ff <= tx_data[4:3];
        end
    end
    sequence s_ctrl;
        tx_valid && tx_ready && cnt_ff == 4'h0;
    endsequence
    sequence s_end;
        tx_valid && tx_ready && tx_last;
    endsequence
    property p_hold_valid;
        tx_valid && !tx_ready |=> tx_valid;
    endproperty
    property p_hold_data;
        tx_valid && !tx_ready |=> $stable(tx_data) && $stable(tx_last);
    endproperty
    property p_rsvd;
        tx_valid && cnt_ff == 4'h0 |-> tx_data[7:5] == 3'h0;
    endproperty
    property p_last_pos;
        tx_valid && cnt_ff == last_at |-> tx_last;
    endproperty
    property p_not_last;
        tx_valid && cnt_ff != last_at |-> !tx_last;
    endproperty
    property p_rx_ready;
        rx_valid |-> rx_ready ##1 !rx_valid;
    endproperty
    property p_idle;
        $rose(i_reset_n) |-> !tx_valid;
    endproperty
    property p_span;
        s_ctrl |-> ##[4:80] s_end;
    endproperty
    a_hold_valid: assert property (p_hold_valid)
        else $error("link octet withdrawn before taken");
    a_hold_data: assert property (p_hold_data)
        else $error("link octet changed before taken");
    a_rsvd: assert property (p_rsvd)
        else $error("reserved control bits not zero");
    a_last_pos: assert property (p_last_pos)
        else $error("final header octet not marked last");
    a_not_last: assert property (p_not_last)
        else $error("header ended early");
    a_rx_ready: assert property (p_rx_ready)
        else $error("receive octet refused or repeated");
    a_idle: assert property (p_idle)
        else $error("header octet without request");
    a_span: assert property (p_span)
        else $error("header not finished in time");
endmodule

// ---- sim/aux_security_header_codec_bench.sv ----
// bench: codec and mac ends joined over the octet link
// assumes 125 MHz clock; expectations built here from field layout
`timescale 1ns/1ps
module aux_security_header_codec_bench;
    localparam logic [63:0] SRC = 64'h0123456789ABCDEF;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic req = 1'b0, sec = 1'b0, hsec = 1'b0, hval = 1'b0, txr = 1'b0;
    ash_pkg::ash_lvl_t lvl = 3'h0, mn = 3'h0, rl;
    ash_pkg::ash_kmode_t kmd = 2'h0, rk;
    logic [63:0] src = 64'h0, rs;
    logic [7:0] idx = 8'h0, hoct = 8'h0, ri, oto;
    logic done, busy, rv, re, ro, rp, rb, hrdy, otv, otl;
    logic [31:0] tally, rf, tal = 32'h0, last_fc = 32'h0;
    logic [4:0] rt;
    logic have_fc = 1'b0;
    logic [8:0] q[$];
    int bad_count = 0, total_checks = 0, dones = 0, rxs = 0, nd = 0, nr = 0;
    ash_link_if lk ();
    ash_codec ash_codec_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_tx_req(req), .i_tx_sec_en(sec), .i_tx_level(lvl),
        .i_tx_kmode(kmd), .i_tx_key_src(src), .i_tx_key_idx(idx),
        .o_tx_busy(busy), .o_tx_done(done), .o_tally(tally),
        .i_min_level(mn),
        .o_rx_valid(rv), .o_rx_level(rl), .o_rx_kmode(rk),
        .o_rx_encrypt(re), .o_rx_tag_len(rt), .o_rx_fc(rf),
        .o_rx_key_src(rs), .o_rx_key_idx(ri), .o_rx_level_ok(ro),
        .o_rx_replay(rp), .o_rx_bad_idx(rb), .link(lk));
    ash_mac #(.DEPTH(16)) ash_mac_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_sec_en(hsec), .i_hdr_valid(hval), .i_hdr_octet(hoct),
        .o_hdr_ready(hrdy), .o_tx_valid(otv), .o_tx_octet(oto),
        .o_tx_last(otl), .i_tx_ready(txr), .link(lk));
    ash_link_properties ash_link_properties_i (.i_clk(i_clk),
        .i_reset_n(i_reset_n), .tx_valid(lk.tx_valid), .tx_data(lk.tx_data),
        .tx_last(lk.tx_last), .tx_ready(lk.tx_ready),
        .rx_valid(lk.rx_valid), .rx_data(lk.rx_data),
        .rx_ready(lk.rx_ready));
    always #4 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        dones <= dones + int'(done === 1'b1);
        rxs <= rxs + int'(rv === 1'b1);
    end
    task chk(input logic [63:0] g, input logic [63:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task wait_ev(input bit rx, input int want);
        for (int k = 0; k < 200; k++) begin
            if ((rx ? rxs : dones) >= want) return;
            @(posedge i_clk);
        end
        bad_count++;
        test_done();
    endtask
    // expected header octets, bit 8 marks the final one
    task build(input logic [2:0] l, input logic [1:0] m,
               input logic [31:0] fc, input logic [7:0] k,
               input logic [2:0] rsv);
        int n;
        n = (m == 2'h3) ? 8 : (m == 2'h2) ? 4 : 0;
        q.push_back({1'b0, rsv, m, l});
        for (int i = 0; i < 4; i++) q.push_back({1'b0, fc[8*i+:8]});
        for (int i = 0; i < n; i++) q.push_back({1'b0, SRC[8*i+:8]});
        if (m != 2'h0) q.push_back({1'b0, k});
        q[q.size()-1][8] = 1'b1;
    endtask
    task send(input logic e, input logic [2:0] l, input logic [1:0] m);
        lvl <= l;
        kmd <= m;
        src <= SRC;
        idx <= {3'h5, l, m};
        sec <= e;
        req <= 1'b1;
        @(posedge i_clk);
        req <= 1'b0;
        nd++;
        if (e) build(l, m, tal, {3'h5, l, m}, 3'h0);
        if (e && l != 3'h0) tal++;
    endtask
    task drain;
        txr <= 1'b1;
        for (int k = 0; k < 200 && q.size() > 0; k++) begin
            @(posedge i_clk);
            if (otv === 1'b1) chk({otl, oto}, q.pop_front());
        end
        txr <= 1'b0;
        chk(q.size(), 0);
        if (q.size() != 0) test_done();
        chk(tally, tal);
    endtask
    task t_tx_modes;
        for (int m = 0; m < 4; m++) begin
            send(1'b1, 3'(2 * m), 2'(m));
            wait_ev(1'b0, nd);
            drain();
        end
        $display("tx modes done");
    endtask
    task t_fill;
        send(1'b1, 3'h7, 2'h3);
        wait_ev(1'b0, nd);
        send(1'b1, 3'h7, 2'h3);
        repeat (20) @(posedge i_clk);
        chk(lk.tx_ready, 1'b0);
        chk(busy, 1'b1);
        drain();
        wait_ev(1'b0, nd);
        $display("fill done");
    endtask
    task t_nosec;
        send(1'b0, 3'h5, 2'h1);
        wait_ev(1'b0, nd);
        repeat (4) @(posedge i_clk);
        chk(otv, 1'b0);
        chk(tally, tal);
        $display("no security done");
    endtask
    task rx_one(input logic [2:0] l, input logic [1:0] m,
                input logic [31:0] fc, input logic [7:0] k);
        logic [8:0] w;
        logic rep;
        rep = l != 3'h0 && have_fc && fc <= last_fc;
        mn <= 3'(l * 3);
        build(l, m, fc, k, 3'h7);
        q.push_front(9'h0AA);
        for (int i = 0; q.size() > 0; i++) begin
            w = q.pop_front();
            hsec <= (i != 0);
            hoct <= w[7:0];
            hval <= 1'b1;
            for (int t = 0; t <= 50; t++) begin
                @(posedge i_clk);
                if (hrdy === 1'b1) break;
                if (t == 50) wait_ev(1'b1, 1000);
            end
        end
        hval <= 1'b0;
        nr++;
        wait_ev(1'b1, nr);
        chk(rl, l);
        chk(rk, m);
        chk(re, l[2]);
        chk(rt, (l[1:0] == 2'h0) ? 5'h00 : 5'h02 << l[1:0]);
        chk(rf, fc);
        chk(rs, (m == 2'h3) ? SRC : (m == 2'h2) ? SRC[31:0] : 64'h0);
        chk(ri, (m == 2'h0) ? 8'h00 : k);
        chk(ro, l[2] >= mn[2] && l[1:0] >= mn[1:0]);
        chk(rp, rep);
        chk(rb, m != 2'h0 && k == 8'h00);
        if (l != 3'h0 && !rep) {have_fc, last_fc} = {1'b1, fc};
    endtask
    task t_rx;
        for (int l = 0; l < 8; l++) begin
            rx_one(3'(l), 2'(l + 1), 32'h100 + l, {3'(l), 5'h00});
        end
        rx_one(3'h5, 2'h2, 32'h103, 8'h11);
        rx_one(3'h0, 2'h3, 32'h0, 8'h22);
        $display("rx done");
    endtask
    initial begin
        repeat (12) @(posedge i_clk);
        #2 i_reset_n = 1'b1;
        repeat (2) @(posedge i_clk);
        t_tx_modes();
        t_fill();
        t_nosec();
        t_rx();
        test_done();
    end
endmodule
